//--- common/fbsp_pkg.sv
// Constants and types for the flow-through burst SRAM port
package fbsp_pkg;
  // ==========================================================
  // Array geometry
  localparam int FBSP_ADDR_W = 19;
  localparam int FBSP_LANES  = 4;
  localparam int FBSP_BYTE_W = 8;
  localparam int FBSP_LANE_W = FBSP_BYTE_W + 1;
  localparam int FBSP_WORD_W = FBSP_LANES * FBSP_LANE_W;
  localparam int FBSP_BUF_DEPTH = 2;

  // ==========================================================
  // Burst sequencing
  localparam logic       FBSP_MODE_LINEAR = 1'b0;
  localparam logic [1:0] FBSP_CNT_START   = 2'h0;
  localparam logic [1:0] FBSP_CNT_STEP    = 2'h1;

  // ==========================================================
  // Sleep entry and exit, in clock cycles
  localparam int         FBSP_SLEEP_CYC   = 2;
  localparam logic [1:0] FBSP_SLEEP_LAST  = 2'(FBSP_SLEEP_CYC - 1);

  // ==========================================================
  // Async input synchroniser: {sleep_req, out_en_n, burst_mode}
  localparam int         FBSP_SYNC_W   = 3;
  localparam int         FBSP_SYNC_ZZ  = 2;
  localparam int         FBSP_SYNC_OE  = 1;
  localparam int         FBSP_SYNC_MD  = 0;
  localparam logic [2:0] FBSP_SYNC_RST = 3'h3;

  typedef enum {
    FBSP_AWAKE,
    FBSP_ENTERING,
    FBSP_ASLEEP,
    FBSP_LEAVING
  } fbsp_sleep_type;

  typedef struct packed {
    logic [FBSP_ADDR_W-1:0] addr;
    logic [FBSP_WORD_W-1:0] data;
    logic [FBSP_LANES-1:0]  mask;
  } fbsp_wr_type;
endpackage : fbsp_pkg

//--- verilog/fbsp_port.sv
// Device-side logic of a flow-through burst synchronous SRAM
`timescale 1ns/1ps

// Behaviour
// [RULE_01] Qualifier high: edge ignored, all state held; output enable and the sleep sequencer still move on such edges
// [RULE_02] Selected load edge captures the address
// [RULE_03] Write strobe high loads a flow-through read
// [RULE_04] Read data driven only while output enabled
// [RULE_05] Deselect on load releases outputs at once
// [RULE_06] Two-bit counter gives bursts of four
// [RULE_07] Strap low linear, high interleaved
// [RULE_08] Linear order counts low bits upward
// [RULE_09] Interleaved order XORs start with index
// [RULE_10] Advance edge steps counter, ignores selects
// [RULE_11] Direction latched at load for whole burst
// [RULE_12] Write issue captures controls, tristates outputs
// [RULE_13] Write data captured on following edge
// [RULE_14] Only selected byte lanes are written
// [RULE_15] Controller never drives while outputs active
// [RULE_16] Controller gives byte selects every write beat
// [RULE_17] Controller reloads address after a deselect
// [RULE_18] Sleep keeps contents; two cycles in, out
// [RULE_19] Access pending at sleep entry is dropped
// [RULE_20] Controller deselects before raising sleep
// [RULE_21] Selects stay inactive during sleep recovery
// [RULE_22] Floating strap means interleaved order
// [RULE_23] Powers up deselected, outputs tristated
// [RULE_24] Selects: first, third low; second high
// [RULE_25] Write with no lanes selected changes nothing
module fbsp_port
  import fbsp_pkg::*;
#(
  parameter int BUF_DEPTH = FBSP_BUF_DEPTH
) (
  input  wire logic                              sys_clk,
  input  wire logic                              reset,
  input  wire logic                              clock_qualify_n,
  input  wire logic                              chip_sel1_n,
  input  wire logic                              chip_sel2,
  input  wire logic                              chip_sel3_n,
  input  wire logic                              advance_load,
  input  wire logic                              write_en_n,
  input  wire logic [FBSP_LANES-1:0]             byte_write_sel_n,
  input  wire logic [FBSP_ADDR_W-1:0]            address,
  input  wire logic [FBSP_LANES*FBSP_BYTE_W-1:0] data_in,
  output logic      [FBSP_LANES*FBSP_BYTE_W-1:0] data_out,
  output logic                                   data_oe_n,
  input  wire logic [FBSP_LANES-1:0]             parity_in,
  output logic      [FBSP_LANES-1:0]             parity_out,
  output logic                                   parity_oe_n,
  input  wire logic                              out_en_n,
  input  wire logic                              sleep_req,
  input  wire logic                              burst_mode
);
  localparam int PTR_W = $clog2(BUF_DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] BUF_FULL = CNT_W'(BUF_DEPTH);
  localparam logic [PTR_W-1:0] PTR_ONE  = PTR_W'(1);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  // ==========================================================
  // Helpers
  function automatic logic [FBSP_WORD_W-1:0] merge_lanes(
    input logic [FBSP_WORD_W-1:0] old_w,
    input logic [FBSP_WORD_W-1:0] new_w,
    input logic [FBSP_LANES-1:0]  mask);
    logic [FBSP_WORD_W-1:0] w;
    w = old_w;
    for (int b = 0; b < FBSP_LANES; b++) begin
      if (mask[b]) begin
        w[b*FBSP_LANE_W +: FBSP_LANE_W] = new_w[b*FBSP_LANE_W +: FBSP_LANE_W];
      end
    end
    return w;
  endfunction : merge_lanes

  function automatic logic [1:0] burst_low(
    input logic [1:0] start,
    input logic [1:0] k,
    input logic       mode);
    if (mode == FBSP_MODE_LINEAR) begin
      return 2'(start + k);
    end
    return start ^ k;
  endfunction : burst_low

  // ==========================================================
  // Synchronisers for the asynchronous pins
  logic [FBSP_SYNC_W-1:0] sync1_q;
  logic [FBSP_SYNC_W-1:0] sync2_q;

  // Reset value of the strap stage reads as interleaved
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync1_q <= FBSP_SYNC_RST; // [RULE_22]
      sync2_q <= FBSP_SYNC_RST;
    end else begin
      sync1_q <= {sleep_req, out_en_n, burst_mode};
      sync2_q <= sync1_q;
    end
  end

  logic sleep_sync;
  logic oe_en;
  logic mode_sel;
  assign sleep_sync = sync2_q[FBSP_SYNC_ZZ];
  assign oe_en      = !sync2_q[FBSP_SYNC_OE];
  assign mode_sel   = sync2_q[FBSP_SYNC_MD]; // [RULE_07]

  // ==========================================================
  // State
  fbsp_sleep_type         sleep_q;
  logic [1:0]             sleep_cnt_q;
  logic                   active_q;
  logic                   is_write_q;
  logic [FBSP_ADDR_W-1:0] base_q;
  logic [1:0]             cnt_q;
  logic                   rd_active_q;
  logic                   wr_pend_q;
  logic [FBSP_ADDR_W-1:0] wr_addr_q;
  logic [FBSP_LANES-1:0]  wr_mask_q;
  fbsp_wr_type            buf_q [BUF_DEPTH];
  logic [PTR_W-1:0]       wptr_q;
  logic [PTR_W-1:0]       rptr_q;
  logic [CNT_W-1:0]       fill_q;
  logic [FBSP_WORD_W-1:0] mem [2**FBSP_ADDR_W];
  logic [FBSP_WORD_W-1:0] out_word_q;
  logic                   data_oe_n_q;
  logic                   parity_oe_n_q;

  // ==========================================================
  // Decode of the current edge
  logic                   awake;
  logic                   buf_ready;
  logic                   ce;
  logic                   sel;
  logic                   load;
  logic                   cont;
  logic                   beat;
  logic                   beat_wr;
  logic [1:0]             cnt_next;
  logic [FBSP_ADDR_W-1:0] cur_addr;
  logic                   push;
  logic                   drain;
  logic                   rd_next;
  logic [FBSP_WORD_W-1:0] wr_word;
  logic [FBSP_WORD_W-1:0] rd_word;
  logic [PTR_W-1:0]       idx;

  assign awake     = (sleep_q == FBSP_AWAKE);
  assign buf_ready = (fill_q != BUF_FULL);
  // A full write buffer stalls the edge like a high qualifier
  assign ce    = !clock_qualify_n && awake && buf_ready; // [RULE_01]
  assign sel   = !chip_sel1_n && chip_sel2 && !chip_sel3_n; // [RULE_24]
  assign load  = ce && !advance_load; // [RULE_02]
  assign cont  = ce && advance_load && active_q; // [RULE_10]
  assign beat  = (load && sel) || cont;
  assign beat_wr  = load ? !write_en_n : is_write_q; // [RULE_11]
  assign cnt_next = load ? FBSP_CNT_START : 2'(cnt_q + FBSP_CNT_STEP);
  // [RULE_06] [RULE_08] [RULE_09]
  assign cur_addr = load ? address :
    {base_q[FBSP_ADDR_W-1:2], burst_low(base_q[1:0], cnt_next, mode_sel)};
  // [RULE_13] [RULE_25]
  assign push  = ce && wr_pend_q && (wr_mask_q != '0);
  // Draining stops only on a high qualifier, never on a full buffer
  assign drain = !clock_qualify_n && (fill_q != '0);
  assign rd_next = ce ? (beat && !beat_wr) : (rd_active_q && awake);

  always_comb begin
    wr_word = '0;
    for (int b = 0; b < FBSP_LANES; b++) begin
      wr_word[b*FBSP_LANE_W +: FBSP_LANE_W] =
        {parity_in[b], data_in[b*FBSP_BYTE_W +: FBSP_BYTE_W]};
    end
  end

  // Reads see buffered writes not yet in the array, oldest first
  always_comb begin
    idx     = rptr_q;
    rd_word = mem[cur_addr];
    for (int i = 0; i < BUF_DEPTH; i++) begin
      idx = PTR_W'(rptr_q + PTR_W'(i));
      if ((CNT_W'(i) < fill_q) && (buf_q[idx].addr == cur_addr)) begin
        rd_word = merge_lanes(rd_word, buf_q[idx].data, buf_q[idx].mask);
      end
    end
    if (push && (wr_addr_q == cur_addr)) begin
      rd_word = merge_lanes(rd_word, wr_word, wr_mask_q);
    end
  end

  // ==========================================================
  // Sleep sequencer
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sleep_q     <= FBSP_AWAKE;
      sleep_cnt_q <= '0;
    end else begin
      unique case (sleep_q)
        FBSP_AWAKE: begin
          if (sleep_sync) begin
            sleep_q     <= FBSP_ENTERING;
            sleep_cnt_q <= '0;
          end
        end
        FBSP_ENTERING: begin
          if (sleep_cnt_q == FBSP_SLEEP_LAST) begin
            sleep_q <= FBSP_ASLEEP; // [RULE_18]
          end else begin
            sleep_cnt_q <= 2'(sleep_cnt_q + 2'h1);
          end
        end
        FBSP_ASLEEP: begin
          if (!sleep_sync) begin
            sleep_q     <= FBSP_LEAVING;
            sleep_cnt_q <= '0;
          end
        end
        FBSP_LEAVING: begin
          if (sleep_sync) begin
            sleep_q     <= FBSP_ENTERING;
            sleep_cnt_q <= '0;
          end else if (sleep_cnt_q == FBSP_SLEEP_LAST) begin
            sleep_q <= FBSP_AWAKE; // [RULE_18]
          end else begin
            sleep_cnt_q <= 2'(sleep_cnt_q + 2'h1);
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Access sequencer
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      active_q    <= 1'b0; // [RULE_23]
      is_write_q  <= 1'b0;
      base_q      <= '0;
      cnt_q       <= FBSP_CNT_START;
      rd_active_q <= 1'b0;
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= '0;
      wr_mask_q   <= '0;
    end else if (!awake) begin
      // Any access not yet in the write buffer is abandoned on sleep entry
      active_q    <= 1'b0; // [RULE_19]
      rd_active_q <= 1'b0;
      wr_pend_q   <= 1'b0;
    end else if (ce) begin
      rd_active_q <= rd_next;
      if (load) begin
        active_q <= sel; // [RULE_05]
        if (sel) begin
          base_q     <= address; // [RULE_02]
          is_write_q <= !write_en_n; // [RULE_03] [RULE_11]
          cnt_q      <= FBSP_CNT_START;
        end
      end else if (cont) begin
        cnt_q <= cnt_next; // [RULE_06]
      end
      wr_pend_q <= beat && beat_wr; // [RULE_12]
      if (beat && beat_wr) begin
        wr_addr_q <= cur_addr;
        wr_mask_q <= ~byte_write_sel_n; // [RULE_14]
      end
    end
  end

  // ==========================================================
  // Two-entry write buffer in front of the array
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wptr_q <= '0;
      rptr_q <= '0;
      fill_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= PTR_W'(wptr_q + PTR_ONE);
      end
      if (drain) begin
        rptr_q <= PTR_W'(rptr_q + PTR_ONE);
      end
      if (push && !drain) begin
        fill_q <= CNT_W'(fill_q + CNT_ONE);
      end else if (drain && !push) begin
        fill_q <= CNT_W'(fill_q - CNT_ONE);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      buf_q[wptr_q] <= '{addr: wr_addr_q, data: wr_word,
                          mask: wr_mask_q}; // [RULE_13]
    end
  end

  // The array has no reset; sleep leaves it untouched
  always_ff @(posedge sys_clk) begin
    if (drain) begin
      mem[buf_q[rptr_q].addr] <= merge_lanes(mem[buf_q[rptr_q].addr],
        buf_q[rptr_q].data, buf_q[rptr_q].mask); // [RULE_14]
    end
  end

  // ==========================================================
  // Output path
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      out_word_q <= '0;
    end else if (beat && !beat_wr) begin
      out_word_q <= rd_word; // [RULE_03]
    end
  end

  // Output enable is sampled every edge, stall or not
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      data_oe_n_q   <= 1'b1; // [RULE_23]
      parity_oe_n_q <= 1'b1;
    end else begin
      data_oe_n_q   <= !(rd_next && oe_en); // [RULE_04] [RULE_12]
      parity_oe_n_q <= !(rd_next && oe_en);
    end
  end

  always_comb begin
    data_out   = '0;
    parity_out = '0;
    for (int b = 0; b < FBSP_LANES; b++) begin
      {parity_out[b], data_out[b*FBSP_BYTE_W +: FBSP_BYTE_W]} =
        out_word_q[b*FBSP_LANE_W +: FBSP_LANE_W];
    end
  end
  assign data_oe_n   = data_oe_n_q;
  assign parity_oe_n = parity_oe_n_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_stall_holds_state: assert property ( // [RULE_01]
    clock_qualify_n && awake |=> $stable(base_q) && $stable(cnt_q)
      && $stable(active_q) && $stable(wr_pend_q))
    else $error("state moved on a stalled edge");
  a_load_takes_addr: assert property ( // [RULE_02]
    load && sel |=> base_q == $past(address) && active_q)
    else $error("address not captured on load");
  a_read_drives_out: assert property ( // [RULE_03]
    load && sel && write_en_n && oe_en |=> !data_oe_n && !parity_oe_n)
    else $error("read beat not driven in its cycle");
  a_oe_gates_drive: assert property ( // [RULE_04]
    !data_oe_n |-> $past(oe_en) && rd_active_q)
    else $error("data driven without output enable");
  a_deselect_releases: assert property ( // [RULE_05]
    load && !sel |=> data_oe_n && !active_q && !wr_pend_q)
    else $error("deselect did not release the bus");
  a_count_steps: assert property ( // [RULE_06]
    cont ##1 cont |=> cnt_q == 2'($past(cnt_q, 2) + 2'h2))
    else $error("burst counter did not step");
  a_linear_next: assert property ( // [RULE_08]
    load && sel && mode_sel == FBSP_MODE_LINEAR ##1 cont
      |-> cur_addr[1:0] == 2'($past(address[1:0]) + 2'h1))
    else $error("linear order broken");
  a_interleave_next: assert property ( // [RULE_09]
    load && sel && mode_sel != FBSP_MODE_LINEAR ##1 cont
      |-> cur_addr[1:0] == ($past(address[1:0]) ^ 2'h1))
    else $error("interleaved order broken");
  a_burst_keeps_dir: assert property ( // [RULE_11]
    load && sel && !write_en_n ##1 cont |=> wr_pend_q && data_oe_n)
    else $error("burst lost its write direction");
  a_write_tristates: assert property ( // [RULE_12]
    wr_pend_q |-> data_oe_n && parity_oe_n)
    else $error("outputs driven during write data cycle");
  a_empty_mask_idle: assert property ( // [RULE_25]
    ce && wr_pend_q && wr_mask_q == '0 |=> $stable(wptr_q))
    else $error("empty byte mask reached the buffer");
  a_sleep_two_cycles: assert property ( // [RULE_18]
    $rose(sleep_q == FBSP_ENTERING) ##1 (sleep_q == FBSP_ENTERING)
      |=> sleep_q == FBSP_ASLEEP)
    else $error("sleep entry not two cycles");
  a_sleep_drops_access: assert property ( // [RULE_19]
    !awake |=> !active_q && !wr_pend_q && data_oe_n)
    else $error("access survived sleep entry");
endmodule : fbsp_port

//--- sim/fbsp_ctrl_model.sv
// Memory controller model driving the burst SRAM port
`timescale 1ns/1ps
module fbsp_ctrl_model
  import fbsp_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic [FBSP_WORD_W-1:0] bus_out,
  input  wire logic                   oe_n,
  output logic      [FBSP_WORD_W-1:0] bus_in,
  output logic                        clock_qualify_n,
  output logic                        chip_sel1_n,
  output logic                        chip_sel2,
  output logic                        chip_sel3_n,
  output logic                        advance_load,
  output logic                        write_en_n,
  output logic      [FBSP_LANES-1:0]  byte_write_sel_n,
  output logic      [FBSP_ADDR_W-1:0] address
);
  logic [FBSP_WORD_W-1:0] wdat   = '0;
  logic [FBSP_WORD_W-1:0] last_q = '0;
  logic                   drive  = 1'b0;

  // ==========================================================
  // Shared bus
  // A released bus shows the inverse of its last level, so stale
  // data can never pass for a capture
  always_comb begin
    if (!oe_n) bus_in = bus_out;
    else if (drive) bus_in = wdat;
    else bus_in = ~last_q;
  end

  always @(posedge sys_clk) last_q <= bus_in;

  initial begin
    clock_qualify_n  = 1'b0;
    {chip_sel1_n, chip_sel2, chip_sel3_n} = 3'h5;
    advance_load     = 1'b0;
    write_en_n       = 1'b1;
    byte_write_sel_n = 4'hf;
    address          = '0;
  end

  // ==========================================================
  // One qualified edge; sel is a mask of active chip selects
  task automatic op(input logic adv, input logic [2:0] sel,
                    input logic we, input logic [FBSP_ADDR_W-1:0] a,
                    input logic [3:0] bws, input logic [35:0] wd,
                    input logic dr);
    @(negedge sys_clk);
    clock_qualify_n  = 1'b0;
    advance_load     = adv;
    {chip_sel1_n, chip_sel2, chip_sel3_n} = {~sel[2], sel[1], ~sel[0]};
    write_en_n       = we;
    address          = a;
    byte_write_sel_n = bws;
    wdat             = wd;
    drive            = dr;
    @(posedge sys_clk);
  endtask : op

  // Qualifier high with a write load offered, harmful if obeyed
  task automatic stall();
    @(negedge sys_clk);
    clock_qualify_n = 1'b1;
    advance_load    = 1'b0;
    write_en_n      = 1'b0;
    {chip_sel1_n, chip_sel2, chip_sel3_n} = 3'h2;
    address         = ~address;
    @(posedge sys_clk);
  endtask : stall
endmodule : fbsp_ctrl_model

//--- sim/fbsp_port_bench.sv
// Self-checking bench for the flow-through burst SRAM port
`timescale 1ns/1ps
module fbsp_port_bench
  import fbsp_pkg::*;
;
  localparam logic [18:0] BASE = 19'h12340;
  localparam logic [2:0]  ALL  = 3'h7;
  logic                   sys_clk = 1'b0;
  logic                   reset;
  logic                   out_en_n;
  logic                   sleep_req;
  logic                   burst_mode;
  logic                   clock_qualify_n;
  logic                   chip_sel1_n;
  logic                   chip_sel2;
  logic                   chip_sel3_n;
  logic                   advance_load;
  logic                   write_en_n;
  logic [3:0]             byte_write_sel_n;
  logic [18:0]            address;
  logic [31:0]            data_out;
  logic [3:0]             parity_out;
  logic                   data_oe_n;
  logic                   parity_oe_n;
  logic [35:0]            bus_in;
  logic [35:0]            mem [logic [18:0]];
  logic [8:0]             rows [5];
  int                     miscompares = 0;
  int                     tests_run   = 0;

  always #2.5 sys_clk = ~sys_clk;

  fbsp_port fbsp_port_inst (
    .sys_clk         (sys_clk),
    .reset           (reset),
    .clock_qualify_n (clock_qualify_n),
    .chip_sel1_n     (chip_sel1_n),
    .chip_sel2       (chip_sel2),
    .chip_sel3_n     (chip_sel3_n),
    .advance_load    (advance_load),
    .write_en_n      (write_en_n),
    .byte_write_sel_n(byte_write_sel_n),
    .address         (address),
    .data_in         (bus_in[31:0]),
    .data_out        (data_out),
    .data_oe_n       (data_oe_n),
    .parity_in       (bus_in[35:32]),
    .parity_out      (parity_out),
    .parity_oe_n     (parity_oe_n),
    .out_en_n        (out_en_n),
    .sleep_req       (sleep_req),
    .burst_mode      (burst_mode)
  );

  fbsp_ctrl_model fbsp_ctrl_model_inst (
    .sys_clk         (sys_clk),
    .bus_out         ({parity_out, data_out}),
    .oe_n            (data_oe_n),
    .bus_in          (bus_in),
    .clock_qualify_n (clock_qualify_n),
    .chip_sel1_n     (chip_sel1_n),
    .chip_sel2       (chip_sel2),
    .chip_sel3_n     (chip_sel3_n),
    .advance_load    (advance_load),
    .write_en_n      (write_en_n),
    .byte_write_sel_n(byte_write_sel_n),
    .address         (address)
  );

  // ==========================================================
  // Helpers
  function automatic logic [35:0] pat(input logic [18:0] a);
    return {a[3:0], a[7:0] ^ 8'h5a, a[15:8], 8'hc3, a[7:0]};
  endfunction : pat

  function automatic logic [35:0] merge(input logic [35:0] o, n,
                                        input logic [3:0] bws_n);
    merge = o;
    for (int b = 0; b < 4; b++) begin
      if (!bws_n[b]) begin
        merge[32+b]    = n[32+b];
        merge[8*b +: 8] = n[8*b +: 8];
      end
    end
  endfunction : merge

  task automatic check(input string what, input logic [35:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic oe_chk(input logic e);
    check("out_enable", {34'h0, data_oe_n, parity_oe_n}, {34'h0, e, e});
  endtask : oe_chk

  task automatic go(input logic adv, input logic [2:0] s, input logic we,
                    input logic [18:0] a, input logic [3:0] bw,
                    input logic [35:0] wd, input logic dr);
    fbsp_ctrl_model_inst.op(adv, s, we, a, bw, wd, dr);
  endtask : go

  task automatic idle(input int n);
    repeat (n) go(1'b0, 3'h0, 1'b1, 19'h0, 4'hf, '0, 1'b0);
    #1;
  endtask : idle

  // Continuation beats offer junk selects, direction and address
  task automatic rd(input logic adv, input logic [18:0] a,
                    input logic [35:0] exp, input logic oe);
    if (adv) go(1'b1, 3'h0, 1'b0, ~a, 4'h0, '0, 1'b0);
    else go(1'b0, ALL, 1'b1, a, 4'hf, '0, 1'b0);
    #1;
    if (!oe) check("read_word", {parity_out, data_out}, exp);
    oe_chk(oe);
  endtask : rd

  task automatic wr(input logic [18:0] a, input logic [3:0] bws,
                    input logic [35:0] w);
    go(1'b0, ALL, 1'b0, a, bws, '0, 1'b0);
    go(1'b0, 3'h0, 1'b1, a, bws, w, 1'b1);
    if (!mem.exists(a)) mem[a] = '0;
    mem[a] = merge(mem[a], w, bws);
  endtask : wr

  // Bounded run guard
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    conclude();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [18:0] a;
    logic [35:0] w;
    reset      = 1'b1;
    out_en_n   = 1'b0;
    sleep_req  = 1'b0;
    burst_mode = 1'b0;
    // Row: strap, then start and the next three low address bits
    rows = '{9'h06c, 9'h0c6, 9'h1b1, 9'h14e, 9'h1e4};
    repeat (8) @(posedge sys_clk);
    #1;
    oe_chk(1'b1);
    @(negedge sys_clk) reset = 1'b0;
    idle(4);
    oe_chk(1'b1);
    for (int b = 0; b < 4; b++) wr(BASE + 19'(b), 4'h0, pat(BASE + 19'(b)));
    foreach (rows[r]) begin
      @(negedge sys_clk) burst_mode = rows[r][8];
      idle(3);
      for (int k = 0; k < 4; k++) begin
        a = BASE + 19'(rows[r][7-2*k -: 2]);
        rd(k != 0, a, pat(a), 1'b0);
      end
    end
    @(negedge sys_clk) burst_mode = FBSP_MODE_LINEAR;
    idle(3);
    rd(1'b0, BASE + 19'h1, pat(BASE + 19'h1), 1'b0);
    fbsp_ctrl_model_inst.stall();
    #1;
    check("stall_hold", {parity_out, data_out}, pat(BASE + 19'h1));
    rd(1'b1, BASE + 19'h2, pat(BASE + 19'h2), 1'b0);
    for (int i = 0; i < 3; i++) begin
      rd(1'b0, BASE, pat(BASE), 1'b0);
      go(1'b0, ALL ^ 3'(1 << i), 1'b1, BASE, 4'hf, '0, 1'b0);
      #1;
      oe_chk(1'b1);
    end
    a = BASE + 19'h8;
    wr(a, 4'h0, pat(a));
    w = ~pat(a);
    go(1'b0, ALL, 1'b0, a, 4'ha, '0, 1'b0);
    #1;
    oe_chk(1'b1);
    // Write data edge also issues a read of the same word
    go(1'b0, ALL, 1'b1, a, 4'ha, w, 1'b1);
    mem[a] = merge(mem[a], w, 4'ha);
    #1;
    check("byte_merge", {parity_out, data_out}, mem[a]);
    wr(a, 4'hf, 36'h0);
    rd(1'b0, a, mem[a], 1'b0);
    @(negedge sys_clk) burst_mode = 1'b1;
    idle(3);
    go(1'b0, ALL, 1'b0, BASE + 19'h12, 4'h0, '0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      a = BASE + 19'h10 + 19'(2'h2 ^ 2'(k));
      mem[a] = ~pat(a);
      go(k == 3 ? 1'b0 : 1'b1, 3'h0, 1'b1, 19'h0, 4'h0, mem[a], 1'b1);
    end
    for (int k = 0; k < 4; k++) begin
      a = BASE + 19'h10 + 19'(k);
      rd(1'b0, a, mem[a], 1'b0);
    end
    @(negedge sys_clk) out_en_n = 1'b1;
    idle(4);
    rd(1'b0, BASE, pat(BASE), 1'b1);
    @(negedge sys_clk) out_en_n = 1'b0;
    idle(1);
    @(negedge sys_clk) sleep_req = 1'b1;
    idle(6);
    rd(1'b0, BASE, '0, 1'b1);
    idle(1);
    @(negedge sys_clk) sleep_req = 1'b0;
    idle(6);
    rd(1'b0, BASE + 19'h8, mem[BASE + 19'h8], 1'b0);
    conclude();
  end
endmodule : fbsp_port_bench
